// file: rtl/chgctl_cfg.svh
// constants for the charger control and throttle block
`ifndef CHGCTL_CFG_SVH
`define CHGCTL_CFG_SVH
`define CC_ADDR_W          8
`define CC_OFF_OPT0        8'h12
`define CC_OFF_STAT        8'h20
`define CC_OFF_PHSTAT      8'h21
`define CC_OFF_OPT1        8'h30
`define CC_OFF_OPT2        8'h31
`define CC_OFF_OPT3        8'h32
`define CC_OFF_PHOPT0      8'h33
`define CC_OFF_PHOPT1      8'h34
`define CC_OFF_STRAP       8'h38
`define CC_BIT_SRCGOOD     11
`define CC_BIT_AUDIO       10
`define CC_BIT_HIZ         15
`define CC_BIT_REV_EN      12
`define CC_BIT_REV_OK      5
`define CC_BIT_DAC_RANGE   2
`define CC_BIT_SYSTEM_POWER_MONITOR_EN     12
`define CC_BIT_SYSTEM_POWER_MONITOR_GAIN   9
`define CC_BIT_EXTEND      14
`define CC_BIT_HOLD        11
`define CC_RST_OPT0        16'h0000
`define CC_RST_OPT1        16'h0000
`define CC_RST_OPT2        16'h0000
`define CC_RST_OPT3        16'h0000
`define CC_RST_PHOPT0      16'h0000
`define CC_RST_PHOPT1      16'h0000
`define CC_RST_PHSTAT      16'h0000
`define CC_CLK_MHZ         100
`define CC_REV_DELAY_MS    10
`define CC_REV_DELAY_CYC   (`CC_REV_DELAY_MS * 1000 * `CC_CLK_MHZ)
`define CC_AUDIO_KHZ       25
`define CC_AUDIO_CYC       ((`CC_CLK_MHZ * 1000) / `CC_AUDIO_KHZ)
`define CC_VFLOOR_OFS_MV   16'd1280
`define CC_DAC_OFS_MV      16'd1280
`define CC_DEAD_CYC        4
`endif

// file: rtl/chgctl_pkg.sv
// types for the charger control and throttle block
package chgctl_pkg;
  typedef enum logic [2:0] {CC_IDLE, CC_DECODE, CC_SAMPLE, CC_RUN, CC_REV_WAIT, CC_REV_RUN,
    CC_HIZ} chgctl_state_t;
  typedef enum logic [1:0] {CC_BUCK, CC_BOOST, CC_BUCKBOOST} chgctl_mode_t;
  typedef enum logic [1:0] {CC_PP_IDLE, CC_PP_OVLD, CC_PP_DC} chgctl_pp_t;
endpackage

// file: rtl/chgctl_top.sv
// charger digital control and cpu throttle logic
// What this block does
// [RULE1] sample bus unloaded, floor is sample minus 1.28V
// [RULE2] decode cell count from pin ratio
// [RULE3] high impedance on low pin or bit
// [RULE4] reverse output only when all conditions hold
// [RULE5] battery overvoltage in reverse stops switching
// [RULE6] dac range bit selects offset
// [RULE7] start after 10 ms, source good if enabled
// [RULE8] switch pattern per converter mode
// [RULE9] classify inductor from monitor pin resistor
// [RULE10] dead time between leg switches
// [RULE11] pfm at light load, 25 kHz floor
// [RULE12] power monitor gain and sense selection
// [RULE13] power monitor off until host enables
// [RULE14] two level limit enable and overload level
// [RULE15] overload time then dc limit
// [RULE16] new peak cycle if load still high
// [RULE17] charging suspended during peak period
// [RULE18] equal times keep overload limit on
// [RULE19] throttle watches nine event sources
// [RULE20] per event enables, boost exit always
// [RULE21] minimum width pulse stretched while active
// [RULE22] extension holds low until host clears
// [RULE23] floor or boost exit latch low
// [RULE24] status bits clear after read when inactive
// [RULE25] decode and sample before first switching
// [RULE26] throttle rests high otherwise
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "chgctl_cfg.svh"
module chgctl_top #(
  parameter int unsigned REV_DELAY_CYC = `CC_REV_DELAY_CYC,
  parameter int unsigned PULSE_UNIT    = 100000
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // analog measurements, already digital
  input  wire logic        analog_supply_up,
  input  wire logic [7:0]  cell_ratio_pct,
  input  wire logic [7:0]  inductor_kohm,
  input  wire logic [15:0] bus_mv,
  input  wire logic        limit_highz_low,
  input  wire logic        reverse_enable_pin,
  input  wire logic        bus_below_uvlo,
  input  wire logic        battery_overvoltage,
  input  wire logic        light_load,
  input  wire logic        load_transient,
  input  wire logic        load_high,
  input  wire logic        pwm_tick,
  input  wire logic [1:0]  buck_boost_sel,
  input  wire logic [8:0]  event_raw,
  // converter outputs
  output logic             gate_hi_a,
  output logic             gate_lo_a,
  output logic             gate_hi_b,
  output logic             gate_lo_b,
  output logic             converter_on,
  output logic             highz_active,
  output logic             source_good_pin,
  output logic             charge_enable,
  output logic             overload_limit_active,
  output logic [4:0]       overload_pct,
  output logic             power_monitor_en,
  output logic             power_monitor_gain,
  output logic [1:0]       power_monitor_rsel,
  output logic [15:0]      input_voltage_floor,
  output logic [15:0]      reverse_dac_offset,
  output logic [2:0]       cell_count,
  output logic [1:0]       inductor_class,
  output logic             pfm_active,
  output logic             cpu_throttle_output_n
);
  logic [15:0] opt0_r, opt1_r, opt2_r, opt3_r, phopt0_r, phopt1_r;
  logic [8:0]  stat_r, stat_nxt, read_seen_r;
  logic        hold_r;
  logic [15:0] rdata_r, floor_r, vsamp_r;
  logic [2:0]  cell_r;
  logic [1:0]  ind_r;
  logic [1:0]  strap_sync_r, strap_meta_r;
  logic [8:0]  ev_meta_r, ev_r;
  logic [31:0] rev_cnt_r, pp_cnt_r, pulse_cnt_r;
  logic [15:0] aud_cnt_r;
  logic [2:0]  dead_cnt_r;
  logic        leg_phase_r, pfm_pulse_r;
  chgctl_pkg::chgctl_state_t st_r, st_nxt;
  chgctl_pkg::chgctl_pp_t    pp_r;
  chgctl_pkg::chgctl_mode_t  mode_w;

  // two flop sync of pin level inputs
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      strap_meta_r <= 2'h0;
      strap_sync_r <= 2'h0;
      ev_meta_r    <= 9'h000;
      ev_r         <= 9'h000;
    end
    else
    begin
      strap_meta_r <= {limit_highz_low, reverse_enable_pin};
      strap_sync_r <= strap_meta_r;
      ev_meta_r    <= event_raw;
      ev_r         <= ev_meta_r;
    end

  wire pin_hiz = strap_sync_r[1];
  wire pin_rev = strap_sync_r[0];

  // register writes
  wire wr_opt0 = reg_wr && reg_addr == `CC_OFF_OPT0;
  wire wr_opt1 = reg_wr && reg_addr == `CC_OFF_OPT1;
  wire wr_opt2 = reg_wr && reg_addr == `CC_OFF_OPT2;
  wire wr_opt3 = reg_wr && reg_addr == `CC_OFF_OPT3;
  wire wr_ph0  = reg_wr && reg_addr == `CC_OFF_PHOPT0;
  wire wr_ph1  = reg_wr && reg_addr == `CC_OFF_PHOPT1;
  wire wr_phs  = reg_wr && reg_addr == `CC_OFF_PHSTAT;
  wire rd_phs  = reg_rd && reg_addr == `CC_OFF_PHSTAT;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      opt0_r   <= `CC_RST_OPT0;
      opt1_r   <= `CC_RST_OPT1; // RULE13
      opt2_r   <= `CC_RST_OPT2;
      opt3_r   <= `CC_RST_OPT3;
      phopt0_r <= `CC_RST_PHOPT0;
      phopt1_r <= `CC_RST_PHOPT1;
    end
    else
    begin
      if (wr_opt0) opt0_r <= reg_wdata;
      if (wr_opt1) opt1_r <= reg_wdata;
      if (wr_opt2) opt2_r <= reg_wdata;
      if (wr_opt3) opt3_r <= reg_wdata;
      if (wr_ph0) phopt0_r <= reg_wdata;
      if (wr_ph1) phopt1_r <= reg_wdata;
    end

  // extension control bits live beside status; the hold bit is set by hardware
  logic [1:0] phctl_r;
  logic       ext_r;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      phctl_r <= 2'h0;
      ext_r   <= 1'b0;
    end
    else if (wr_phs)
    begin
      phctl_r <= reg_wdata[13:12];
      ext_r   <= reg_wdata[`CC_BIT_EXTEND];
    end

  // read mux
  always_comb
  begin
    case (reg_addr)
      `CC_OFF_OPT0:   rdata_r = opt0_r;
      `CC_OFF_OPT1:   rdata_r = opt1_r;
      `CC_OFF_OPT2:   rdata_r = opt2_r;
      `CC_OFF_OPT3:   rdata_r = opt3_r;
      `CC_OFF_PHOPT0: rdata_r = phopt0_r;
      `CC_OFF_PHOPT1: rdata_r = phopt1_r;
      `CC_OFF_PHSTAT: rdata_r = {1'b0, ext_r, phctl_r, hold_r, 2'b00, stat_r};
      `CC_OFF_STAT:   rdata_r = {9'h000, st_r, 1'b0, pp_r, cpu_throttle_output_n};
      `CC_OFF_STRAP:  rdata_r = {floor_r[15:5], cell_r, ind_r};
      default:        rdata_r = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= reg_rd ? rdata_r : 16'h0000;

  // strap decode; pin ratio thresholds sit midway between nominal points
  wire [2:0] cell_dec = (cell_ratio_pct >= 8'd65) ? 3'd4 :
                        (cell_ratio_pct >= 8'd48) ? 3'd3 :
                        (cell_ratio_pct >= 8'd33) ? 3'd2 : 3'd1; // RULE2
  wire [1:0] ind_dec  = (inductor_kohm >= 8'd153) ? 2'd2 :
                        (inductor_kohm >= 8'd115) ? 2'd1 : 2'd0; // RULE9

  wire hiz_w   = pin_hiz || opt3_r[`CC_BIT_HIZ]; // RULE3
  wire rev_ok  = pin_rev && opt3_r[`CC_BIT_REV_EN] && opt3_r[`CC_BIT_REV_OK] &&
                 bus_below_uvlo && (opt3_r[15:0] != 16'h0000) && cell_r != 3'd0; // RULE4

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      chgctl_pkg::CC_IDLE:     if (analog_supply_up) st_nxt = chgctl_pkg::CC_DECODE;
      chgctl_pkg::CC_DECODE:   st_nxt = chgctl_pkg::CC_SAMPLE; // RULE25
      chgctl_pkg::CC_SAMPLE:   st_nxt = hiz_w ? chgctl_pkg::CC_HIZ :
                                        rev_ok ? chgctl_pkg::CC_REV_WAIT : chgctl_pkg::CC_RUN;
      chgctl_pkg::CC_RUN:      if (hiz_w) st_nxt = chgctl_pkg::CC_HIZ;
                               else if (rev_ok) st_nxt = chgctl_pkg::CC_REV_WAIT;
      chgctl_pkg::CC_REV_WAIT: if (hiz_w) st_nxt = chgctl_pkg::CC_HIZ; // RULE3
                               else if (!rev_ok) st_nxt = chgctl_pkg::CC_RUN;
                               else if (rev_cnt_r >= REV_DELAY_CYC - 1)
                                 st_nxt = chgctl_pkg::CC_REV_RUN; // RULE7
      chgctl_pkg::CC_REV_RUN:  if (hiz_w) st_nxt = chgctl_pkg::CC_HIZ; // RULE3
                               else if (!rev_ok) st_nxt = chgctl_pkg::CC_RUN;
      chgctl_pkg::CC_HIZ:      if (!hiz_w) st_nxt = chgctl_pkg::CC_SAMPLE;
      default:                 st_nxt = chgctl_pkg::CC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      st_r      <= chgctl_pkg::CC_IDLE;
      rev_cnt_r <= 32'h0;
      cell_r    <= 3'd0;
      ind_r     <= 2'd0;
      vsamp_r   <= 16'h0000;
    end
    else
    begin
      st_r      <= st_nxt;
      rev_cnt_r <= (st_r == chgctl_pkg::CC_REV_WAIT && rev_ok) ? rev_cnt_r + 32'd1 : 32'h0;
      if (st_r == chgctl_pkg::CC_DECODE)
      begin
        cell_r <= cell_dec;
        ind_r  <= ind_dec;
      end
      if (st_r == chgctl_pkg::CC_SAMPLE) vsamp_r <= bus_mv; // RULE1
    end

  assign floor_r = (vsamp_r > `CC_VFLOOR_OFS_MV) ? vsamp_r - `CC_VFLOOR_OFS_MV : 16'h0000; // RULE1
  assign input_voltage_floor = floor_r;
  assign reverse_dac_offset  = opt3_r[`CC_BIT_DAC_RANGE] ? 16'h0000 : `CC_DAC_OFS_MV; // RULE6
  assign cell_count          = cell_r;
  assign inductor_class      = ind_r;
  assign highz_active        = st_r == chgctl_pkg::CC_HIZ;
  wire run_w = (st_r == chgctl_pkg::CC_RUN) ||
               (st_r == chgctl_pkg::CC_REV_RUN && !battery_overvoltage); // RULE5
  assign converter_on        = run_w;
  assign source_good_pin     = st_r == chgctl_pkg::CC_REV_RUN && opt0_r[`CC_BIT_SRCGOOD]; // RULE7
  assign power_monitor_en    = opt1_r[`CC_BIT_SYSTEM_POWER_MONITOR_EN]; // RULE13
  assign power_monitor_gain  = opt1_r[`CC_BIT_SYSTEM_POWER_MONITOR_GAIN]; // RULE12
  assign power_monitor_rsel  = opt1_r[11:10]; // RULE12
  assign overload_pct        = phopt0_r[15:11]; // RULE14

  // pfm with audio floor: force a pulse if the period reaches 40 us
  wire aud_due = opt0_r[`CC_BIT_AUDIO] && aud_cnt_r >= 16'(`CC_AUDIO_CYC - 1);
  wire tick_w  = light_load ? (pwm_tick || aud_due) : pwm_tick; // RULE11
  assign pfm_active = light_load && run_w; // RULE11
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      aud_cnt_r <= 16'h0000;
    else
      aud_cnt_r <= tick_w ? 16'h0000 : aud_cnt_r + 16'd1;

  // leg switching with dead time
  assign mode_w = chgctl_pkg::chgctl_mode_t'(buck_boost_sel);
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      leg_phase_r <= 1'b0;
      dead_cnt_r  <= 3'd0;
    end
    else if (tick_w && run_w)
    begin
      leg_phase_r <= ~leg_phase_r;
      dead_cnt_r  <= 3'(`CC_DEAD_CYC); // RULE10
    end
    else if (dead_cnt_r != 3'd0)
      dead_cnt_r <= dead_cnt_r - 3'd1;

  wire dead = dead_cnt_r != 3'd0 || !run_w; // RULE10
  always_comb
  begin
    gate_hi_a = 1'b0;
    gate_lo_a = 1'b0;
    gate_hi_b = 1'b0;
    gate_lo_b = 1'b0;
    if (!dead)
      case (mode_w) // RULE8
        chgctl_pkg::CC_BUCK:
        begin
          gate_hi_a = leg_phase_r;
          gate_lo_a = !leg_phase_r;
          gate_hi_b = 1'b1;
        end
        chgctl_pkg::CC_BOOST:
        begin
          gate_hi_a = 1'b1;
          gate_hi_b = !leg_phase_r;
          gate_lo_b = leg_phase_r;
        end
        default:
        begin
          gate_hi_a = leg_phase_r;
          gate_lo_a = !leg_phase_r;
          gate_hi_b = !leg_phase_r;
          gate_lo_b = leg_phase_r;
        end
      endcase
  end

  // peak power timing, overload time in PULSE_UNIT cycles, max period in units of 4 x PULSE_UNIT
  wire [31:0] t_ovld = (32'(opt2_r[15:14]) + 32'd1) * PULSE_UNIT; // RULE15
  wire [31:0] t_max  = (32'(opt2_r[9:8]) + 32'd1) * PULSE_UNIT * 32'd4;
  wire pp_en = opt2_r[13:12] != 2'b00; // RULE14
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      pp_r     <= chgctl_pkg::CC_PP_IDLE;
      pp_cnt_r <= 32'h0;
    end
    else if (!pp_en)
      pp_r <= chgctl_pkg::CC_PP_IDLE;
    else
      case (pp_r)
        chgctl_pkg::CC_PP_IDLE: if (load_transient)
        begin
          pp_r     <= chgctl_pkg::CC_PP_OVLD; // RULE15
          pp_cnt_r <= 32'h0;
        end
        default:
        begin
          pp_cnt_r <= pp_cnt_r + 32'd1;
          if (pp_cnt_r + 32'd1 >= t_ovld && t_ovld < t_max)
            pp_r <= chgctl_pkg::CC_PP_DC; // RULE18
          if (pp_cnt_r + 32'd1 >= t_max)
          begin
            pp_cnt_r <= 32'h0;
            pp_r     <= load_high ? chgctl_pkg::CC_PP_OVLD : chgctl_pkg::CC_PP_IDLE; // RULE16
          end
        end
      endcase
  assign overload_limit_active = pp_r == chgctl_pkg::CC_PP_OVLD ||
                                 (pp_en && opt2_r[15:14] == opt2_r[9:8]); // RULE18
  assign charge_enable = pp_r == chgctl_pkg::CC_PP_IDLE && run_w; // RULE17

  // throttle: bit 8 is boost exit, always enabled
  wire [8:0] ev_act  = ev_r & {1'b1, phopt1_r[7:0]}; // RULE19 RULE20
  wire       any_ev  = |ev_act;
  wire       latch_ev = ev_act[8] || ev_act[7]; // RULE23
  wire [31:0] min_w  = (32'(phctl_r) + 32'd1) * PULSE_UNIT;
  assign stat_nxt = ev_act | (stat_r & ~(read_seen_r & ~ev_act)); // RULE24

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      stat_r      <= 9'(`CC_RST_PHSTAT);
      read_seen_r <= 9'h000;
      hold_r      <= 1'b0;
      pulse_cnt_r <= 32'h0;
    end
    else
    begin
      stat_r      <= stat_nxt;
      read_seen_r <= rd_phs ? stat_r : (read_seen_r & stat_r & ~ev_act);
      if (any_ev)
        pulse_cnt_r <= min_w; // RULE21
      else if (pulse_cnt_r != 32'h0)
        pulse_cnt_r <= pulse_cnt_r - 32'd1;
      if (latch_ev || (any_ev && ext_r))
        hold_r <= 1'b1; // RULE22 RULE23
      else if (wr_phs && !reg_wdata[`CC_BIT_HOLD])
        hold_r <= 1'b0; // RULE22
    end

  assign cpu_throttle_output_n = !(any_ev || pulse_cnt_r != 32'h0 || hold_r); // RULE26

  legs_apart_a: assert property (@(posedge ref_clk) disable iff (rst)
    !(gate_hi_a && gate_lo_a) && !(gate_hi_b && gate_lo_b)) // RULE10
    else $error("leg shoot through");
  floor_held_a: assert property (@(posedge ref_clk) disable iff (rst)
    hold_r && !(wr_phs && !reg_wdata[`CC_BIT_HOLD]) |=> !cpu_throttle_output_n) // RULE22
    else $error("held throttle released");
  throttle_event_a: assert property (@(posedge ref_clk) disable iff (rst)
    any_ev |=> !cpu_throttle_output_n [*2]) // RULE21
    else $error("throttle pulse missing");
  system_power_monitor_enable_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(power_monitor_en) |-> $past(wr_opt1)) // RULE13
    else $error("power monitor enabled without write");
  hiz_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
    hiz_w && st_r == chgctl_pkg::CC_RUN |=> highz_active) // RULE3
    else $error("high impedance not entered");
  rev_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    st_r == chgctl_pkg::CC_REV_RUN |-> $past(rev_ok)) // RULE4
    else $error("reverse without conditions");
  batov_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
    st_r == chgctl_pkg::CC_REV_RUN && battery_overvoltage |-> !gate_hi_a && !gate_lo_a) // RULE5
    else $error("switching during battery overvoltage");
  charge_suspend_a: assert property (@(posedge ref_clk) disable iff (rst)
    pp_r != chgctl_pkg::CC_PP_IDLE |-> !charge_enable) // RULE17
    else $error("charging during peak period");
  status_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    ev_act[0] |=> stat_r[0]) // RULE24
    else $error("status bit not set");
  dac_offset_a: assert property (@(posedge ref_clk) disable iff (rst)
    !opt3_r[`CC_BIT_DAC_RANGE] |-> reverse_dac_offset == `CC_DAC_OFS_MV) // RULE6
    else $error("dac offset wrong");
endmodule // chgctl_top
`default_nettype wire

// file: testbench/chgctl_cpu_model.sv
// cpu side model: watches the active-low throttle line and measures each low pulse
`timescale 1ns/1ps
`default_nettype none
module chgctl_cpu_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // throttle line from the charger
  input  wire logic        cpu_throttle_output_n,
  // measurement results
  output logic      [15:0] last_low_cyc,
  output logic      [15:0] pulse_cnt
);
  logic [15:0] run_r;
  // width is counted in whole cycles, so a measured width can be off by up to one cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      run_r        <= 16'h0000;
      last_low_cyc <= 16'h0000;
      pulse_cnt    <= 16'h0000;
    end
    else if (cpu_throttle_output_n === 1'b0)
    begin
      run_r <= run_r + 16'h0001;
    end
    else if (run_r != 16'h0000)
    begin
      last_low_cyc <= run_r;
      pulse_cnt    <= pulse_cnt + 16'h0001;
      run_r        <= 16'h0000;
    end
  end
endmodule // chgctl_cpu_model
`default_nettype wire

// file: testbench/charger_control_and_cpu_throttle_test.sv
// self-checking bench for the charger control and throttle block
`timescale 1ns/1ps
`default_nettype none
module charger_control_and_cpu_throttle_test;
  localparam int unsigned REV_DLY = 50;
  localparam int unsigned PUNIT   = 10;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        supply_up = 1'b0, hz_low = 1'b0, rev_pin = 1'b0, uvlo = 1'b0, bat_ov = 1'b0;
  logic        light = 1'b0, transient = 1'b0, load_hi = 1'b0, tick = 1'b0;
  logic [1:0]  bb_sel = 2'h0;
  logic [8:0]  ev = 9'h000;
  logic [7:0]  cell_pct = 8'h37, ind_k = 8'h89;
  logic [15:0] bus_v = 16'h2710;
  logic [2:0]  tcnt = 3'h0;
  logic        tick_en = 1'b1, legs_q = 1'b0;
  int          toggles = 0;
  logic        ga, gb, gc, gd, conv_on, hz, src_good, chg_en, ovl_on, pm_en, pm_gain, pfm;
  logic        thr_n;
  logic [4:0]  ovl_pct;
  logic [1:0]  pm_rsel, ind_cls;
  logic [15:0] vfloor, dac_ofs, low_cyc, pulses, d;
  logic [2:0]  cells;
  int          error_cnt = 0;
  int          n_checks = 0;
  always #5 ref_clk = ~ref_clk;
  // a tick every eighth cycle leaves the legs room to conduct after dead time
  always @(posedge ref_clk)
  begin
    tcnt <= tcnt + 3'h1;
    tick <= tcnt == 3'h7 && tick_en;
  end
  always @(posedge ref_clk)
  begin
    legs_q <= ga || gb;
    if ((ga || gb) && !legs_q)
      toggles <= toggles + 1;
  end
  chgctl_top #(.REV_DELAY_CYC(REV_DLY), .PULSE_UNIT(PUNIT)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .analog_supply_up(supply_up),
    .cell_ratio_pct(cell_pct), .inductor_kohm(ind_k), .bus_mv(bus_v),
    .limit_highz_low(hz_low), .reverse_enable_pin(rev_pin), .bus_below_uvlo(uvlo),
    .battery_overvoltage(bat_ov), .light_load(light), .load_transient(transient),
    .load_high(load_hi), .pwm_tick(tick), .buck_boost_sel(bb_sel), .event_raw(ev),
    .gate_hi_a(ga), .gate_lo_a(gb), .gate_hi_b(gc), .gate_lo_b(gd), .converter_on(conv_on),
    .highz_active(hz), .source_good_pin(src_good), .charge_enable(chg_en),
    .overload_limit_active(ovl_on), .overload_pct(ovl_pct), .power_monitor_en(pm_en),
    .power_monitor_gain(pm_gain), .power_monitor_rsel(pm_rsel), .input_voltage_floor(vfloor),
    .reverse_dac_offset(dac_ofs), .cell_count(cells), .inductor_class(ind_cls),
    .pfm_active(pfm), .cpu_throttle_output_n(thr_n));
  chgctl_cpu_model i_cpu (.ref_clk(ref_clk), .rst(rst), .cpu_throttle_output_n(thr_n),
    .last_low_cyc(low_cyc), .pulse_cnt(pulses));
  task automatic finish_test;
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi, input string what);
    n_checks++;
    if (!(got >= lo && got <= hi) || $isunknown(got))
    begin
      error_cnt++;
      $display("Error at %0t: %s got %0d outside %0d..%0d", $time, what, got, lo, hi);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic t_reset_and_start;
    chk({15'h0, thr_n}, 16'h0001, "throttle idle");
    chk({15'h0, pm_en}, 16'h0000, "power monitor at reset");
    rd(8'hF0, d);
    chk(d, 16'h0000, "unmapped read");
    supply_up <= 1'b1;
    cyc(12);
    chk({13'h0, cells}, 16'h0003, "cell count");
    chk({14'h0, ind_cls}, 16'h0001, "inductor class");
    chk(vfloor, 16'h2210, "voltage floor");
  endtask
  task automatic t_config;
    wr(8'h30, 16'h1A00);
    wr(8'h33, 16'h9800);
    wr(8'h32, 16'h1020);
    cyc(2);
    chk({13'h0, pm_en, pm_gain, pm_rsel[1]}, 16'h0007, "monitor enable and gain");
    chk({14'h0, pm_rsel}, 16'h0002, "sense select");
    chk({11'h0, ovl_pct}, 16'h0013, "overload level");
    chk(dac_ofs, 16'h0500, "dac offset on");
    wr(8'h32, 16'h1024);
    cyc(2);
    chk(dac_ofs, 16'h0000, "dac offset off");
    rd(8'h33, d);
    chk(d, 16'h9800, "readback");
  endtask
  task automatic t_peak;
    wr(8'h31, 16'h3100);
    light <= 1'b1;
    load_hi <= 1'b1;
    transient <= 1'b1;
    cyc(1);
    transient <= 1'b0;
    cyc(3);
    chk({13'h0, pfm, ovl_on, chg_en}, 16'h0006, "overload phase");
    cyc(16);
    chk({14'h0, ovl_on, chg_en}, 16'h0000, "dc phase");
    cyc(64);
    chk({15'h0, ovl_on}, 16'h0001, "new peak cycle");
    load_hi <= 1'b0;
    light <= 1'b0;
    cyc(100);
    chk({14'h0, pfm, chg_en}, 16'h0001, "charging resumes");
    wr(8'h31, 16'h7100);
    transient <= 1'b1;
    cyc(1);
    transient <= 1'b0;
    cyc(200);
    chk({15'h0, ovl_on}, 16'h0001, "overload kept on");
    wr(8'h31, 16'h0000);
  endtask
  task automatic throttle_hit(input logic [8:0] e);
    ev <= e;
    cyc(1);
    ev <= 9'h000;
  endtask
  task automatic t_throttle;
    wr(8'h34, 16'h0001);
    throttle_hit(9'h002);
    cyc(30);
    chk(pulses, 16'h0000, "disabled event");
    throttle_hit(9'h001);
    cyc(30);
    chk(pulses, 16'h0001, "one pulse");
    chk_rng(low_cyc, PUNIT, PUNIT + 3, "pulse width");
    rd(8'h21, d);
    chk(d & 16'h01FF, 16'h0001, "status set");
    rd(8'h21, d);
    chk(d & 16'h01FF, 16'h0000, "status cleared");
    wr(8'h21, 16'h1000);
    ev <= 9'h001;
    cyc(40);
    ev <= 9'h000;
    cyc(30);
    chk_rng(low_cyc, 40 + 2 * PUNIT - 2, 40 + 2 * PUNIT + 3, "stretched width");
    wr(8'h21, 16'h4000);
    throttle_hit(9'h001);
    cyc(60);
    chk({15'h0, thr_n}, 16'h0000, "extension hold");
    wr(8'h21, 16'h0000);
    cyc(4);
    chk({15'h0, thr_n}, 16'h0001, "hold released");
    throttle_hit(9'h100);
    cyc(60);
    chk({15'h0, thr_n}, 16'h0000, "boost exit latch");
    wr(8'h21, 16'h0000);
    cyc(4);
    chk({15'h0, thr_n}, 16'h0001, "latch cleared");
  endtask
  task automatic t_reverse;
    int         on;
    logic [2:0] pat;
    for (int m = 0; m < 3; m++)
    begin
      bb_sel <= m[1:0];
      on = 0;
      cyc(8);
      repeat (16)
      begin
        cyc(1);
        pat = (m == 1) ? {ga, gb, gc ^ gd} :
              {ga ^ gb, (m == 2) ? gc ^ gd : gc, (m == 2) ? 1'b0 : gd};
        if (ga || gb || gc || gd)
        begin
          on++;
          chk({13'h0, pat}, (m == 1) ? 16'h0005 : 16'h0006, "leg pattern");
        end
      end
      chk(16'(on), 16'h0008, "dead time share");
    end
    uvlo <= 1'b1;
    rev_pin <= 1'b1;
    cyc(REV_DLY - 20);
    chk({15'h0, conv_on}, 16'h0000, "reverse not yet");
    cyc(30);
    chk({14'h0, conv_on, src_good}, 16'h0002, "reverse running");
    wr(8'h12, 16'h0800);
    cyc(3);
    chk({15'h0, src_good}, 16'h0001, "source good");
    bat_ov <= 1'b1;
    cyc(4);
    chk({15'h0, conv_on}, 16'h0000, "overvoltage stop");
  endtask
  task automatic t_highz;
    hz_low <= 1'b1;
    cyc(6);
    chk({15'h0, hz}, 16'h0001, "high impedance");
  endtask
  task automatic t_audio;
    int t0;
    tick_en <= 1'b0;
    light <= 1'b1;
    cyc(10);
    wr(8'h12, 16'h0400);
    t0 = toggles;
    cyc(8100);
    chk(16'(toggles - t0), 16'h0002, "audio floor toggles");
    wr(8'h12, 16'h0000);
    t0 = toggles;
    cyc(4100);
    chk(16'(toggles - t0), 16'h0000, "no floor when off");
    light <= 1'b0;
    tick_en <= 1'b1;
  endtask
  task automatic t_restrap;
    cell_pct <= 8'h19;
    ind_k <= 8'h5D;
    bus_v <= 16'h1388;
    hz_low <= 1'b0;
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    chk({15'h0, pm_en}, 16'h0000, "monitor off after reset");
    cyc(12);
    chk({13'h0, cells}, 16'h0001, "one cell");
    chk({14'h0, ind_cls}, 16'h0000, "small inductor");
    chk(vfloor, 16'h0E88, "low bus floor");
  endtask
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    error_cnt++;
    finish_test;
  end
  initial
  begin
    cyc(20);
    rst <= 1'b0;
    cyc(1);
    t_reset_and_start;
    t_config;
    t_peak;
    t_throttle;
    t_audio;
    t_reverse;
    t_highz;
    t_restrap;
    finish_test;
  end
endmodule // charger_control_and_cpu_throttle_test
`default_nettype wire
